// ### rtl/homing_params.svh
// Constants for the speech codec homing block.
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

`define FRAME_LAST_SAMPLE  8'h9f
`define SAMPLE_VALID_MASK  16'hfff8
`define ENC_HOME_SAMPLE    16'h0008
`define DEC_LAR_COUNT      7'h08
`define DEC_SUB_LAST_POS   5'h10
`define DEC_EARLY_IDX      7'h18
`define DEC_LAST_IDX       7'h4b
`define DEC_LAST_SUB       2'h3
`define LAR_HOME_1         7'h09
`define LAR_HOME_2         7'h17
`define LAR_HOME_3         7'h0f
`define LAR_HOME_4         7'h08
`define LAR_HOME_5         7'h07
`define LAR_HOME_6         7'h03
`define LAR_HOME_7         7'h03
`define LAR_HOME_8         7'h02
`define LAR_MASK_6B        7'h3f
`define LAR_MASK_5B        7'h1f
`define LAR_MASK_4B        7'h0f
`define LAR_MASK_3B        7'h07
`define LAG_MASK           7'h7f
`define GAIN_MASK          7'h03
`define XMAX_MASK          7'h3f
`define PULSE_MASK         7'h07
`define LAG_HOME           7'h28
`define PULSE_HOME         7'h04
`define PULSE_ALT          7'h03
`define PULSE_ALT_POS      5'h08
`define POS_LAG            5'h00
`define POS_GAIN           5'h01
`define POS_GRID           5'h02
`define POS_XMAX           5'h03
`define DEEMPH_BETA        32'sh00006e14
`define DEEMPH_ROUND       32'sh00004000
`define Q15_SHIFT          15
`define SAT_POS            16'sh7fff
`define SAT_NEG            16'sh8000

`endif

// ### rtl/homing_pkg.sv
// Types shared by the speech codec homing block.
package homing_pkg;
	typedef enum logic [0:0] {
		ENC_SCAN = 1'b0,
		ENC_WAIT = 1'b1
	} enc_state_t;
	typedef enum logic [0:0] {
		DEC_PARAMS = 1'b0,
		DEC_SYNTH  = 1'b1
	} dec_state_t;
endpackage

// ### rtl/codec_homing.sv
// Homing detection, home-state control and de-emphasis output filter.
`timescale 1ns/1ps
`default_nettype none
`include "homing_params.svh"

module codec_homing (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        enc_sample_valid,
	input  wire logic [15:0] enc_sample,
	output logic             enc_sample_ready,
	input  wire logic        enc_frame_done,
	output logic             enc_state_clear,
	output logic             enc_home,
	input  wire logic        dec_param_valid,
	input  wire logic [15:0] dec_param,
	input  wire logic        dec_bad_frame,
	output logic             dec_param_ready,
	input  wire logic        syn_valid,
	input  wire logic [15:0] syn_sample,
	output logic             syn_ready,
	output logic             out_valid,
	output logic [15:0]      out_sample,
	output logic             dec_state_clear,
	output logic             dec_home
);

	////////////////////////////////////////////////////////////////////////////
	// Encoder direction.

	homing_pkg::enc_state_t enc_state;
	logic [7:0]             enc_count;
	logic                   enc_match;
	logic                   enc_pending;
	logic                   enc_take;
	logic                   enc_sample_ok;

	assign enc_sample_ready = (enc_state == homing_pkg::ENC_SCAN);
	assign enc_take         = enc_sample_valid && enc_sample_ready;
	assign enc_sample_ok    = (enc_sample & `SAMPLE_VALID_MASK) == `ENC_HOME_SAMPLE;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			enc_count <= 8'h00;
		end else if (enc_take) begin
			enc_count <= (enc_count == `FRAME_LAST_SAMPLE) ? 8'h00 : enc_count + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			enc_match <= 1'b1;
		end else if (enc_take) begin
			enc_match <= (enc_count == `FRAME_LAST_SAMPLE) ? 1'b1 : enc_match && enc_sample_ok;
		end
	end

	// The input stalls while the datapath finishes the frame, so the state
	// reset can never land in the middle of the next frame.
	// wait for normal processing
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			enc_state   <= homing_pkg::ENC_SCAN;
			enc_pending <= 1'b0;
		end else begin
			case (enc_state)
				homing_pkg::ENC_SCAN: begin
					if (enc_take && enc_count == `FRAME_LAST_SAMPLE) begin
						enc_state   <= homing_pkg::ENC_WAIT;
						enc_pending <= enc_match && enc_sample_ok;
					end
				end
				homing_pkg::ENC_WAIT: begin
					if (enc_frame_done) begin
						enc_state   <= homing_pkg::ENC_SCAN;
						enc_pending <= 1'b0;
					end
				end
				default: begin
					enc_state   <= homing_pkg::ENC_SCAN;
					enc_pending <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			enc_state_clear <= 1'b0;
			enc_home        <= 1'b1;
		end else begin
			enc_state_clear <= (enc_state == homing_pkg::ENC_WAIT) && enc_frame_done && enc_pending;
			if ((enc_state == homing_pkg::ENC_WAIT) && enc_frame_done) begin
				enc_home <= enc_pending;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoder parameter checking.

	homing_pkg::dec_state_t dec_state;
	logic [6:0]             dec_idx;
	logic [4:0]             dec_pos;
	logic [1:0]             dec_sub;
	logic                   dec_match;
	logic                   dec_param_ok;
	logic                   dec_ptake;
	logic                   dec_replace;
	logic                   dec_pending;
	logic [6:0]             exp_val;
	logic [6:0]             exp_mask;
	logic [7:0]             out_count;
	logic                   out_done;

	assign dec_param_ready = (dec_state == homing_pkg::DEC_PARAMS);
	assign dec_ptake       = dec_param_valid && dec_param_ready;

	always_comb begin
		exp_val  = 7'h00;
		exp_mask = `LAR_MASK_6B;
		if (dec_idx < `DEC_LAR_COUNT) begin
			case (dec_idx[2:0])
				3'h0: begin exp_val = `LAR_HOME_1; exp_mask = `LAR_MASK_6B; end
				3'h1: begin exp_val = `LAR_HOME_2; exp_mask = `LAR_MASK_6B; end
				3'h2: begin exp_val = `LAR_HOME_3; exp_mask = `LAR_MASK_5B; end
				3'h3: begin exp_val = `LAR_HOME_4; exp_mask = `LAR_MASK_5B; end
				3'h4: begin exp_val = `LAR_HOME_5; exp_mask = `LAR_MASK_4B; end
				3'h5: begin exp_val = `LAR_HOME_6; exp_mask = `LAR_MASK_4B; end
				3'h6: begin exp_val = `LAR_HOME_7; exp_mask = `LAR_MASK_3B; end
				default: begin exp_val = `LAR_HOME_8; exp_mask = `LAR_MASK_3B; end
			endcase
		end else begin
			case (dec_pos)
				`POS_LAG:  begin exp_val = `LAG_HOME; exp_mask = `LAG_MASK; end
				`POS_GAIN: begin exp_val = 7'h00; exp_mask = `GAIN_MASK; end
				`POS_GRID: begin exp_val = 7'h00; exp_mask = `GAIN_MASK; end
				`POS_XMAX: begin exp_val = 7'h00; exp_mask = `XMAX_MASK; end
				default: begin
					exp_mask = `PULSE_MASK;
					exp_val  = (dec_sub == `DEC_LAST_SUB && dec_pos == `PULSE_ALT_POS)
						? `PULSE_ALT : `PULSE_HOME;
				end
			endcase
		end
	end

	assign dec_param_ok = (dec_param[6:0] & exp_mask) == exp_val;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_idx <= 7'h00;
			dec_pos <= 5'h00;
			dec_sub <= 2'h0;
		end else if (dec_ptake) begin
			dec_idx <= (dec_idx == `DEC_LAST_IDX) ? 7'h00 : dec_idx + 7'h01;
			if (dec_idx >= `DEC_LAR_COUNT) begin
				dec_pos <= (dec_pos == `DEC_SUB_LAST_POS) ? 5'h00 : dec_pos + 5'h01;
				if (dec_pos == `DEC_SUB_LAST_POS) begin
					dec_sub <= dec_sub + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_match <= 1'b1;
		end else if (dec_ptake) begin
			dec_match <= (dec_idx == `DEC_LAST_IDX) ? 1'b1 : dec_match && dec_param_ok;
		end
	end

	// The replacement is decided at the end of sub-frame one, but output still waits
	// for the last parameter; a later bad-frame flag still cancels it.
	// early decision in home state
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_replace <= 1'b0;
			dec_pending <= 1'b0;
		end else if (dec_ptake && dec_idx == `DEC_EARLY_IDX) begin
			dec_replace <= dec_home && dec_match && dec_param_ok && !dec_bad_frame;
		end else if (dec_ptake && dec_idx == `DEC_LAST_IDX) begin
			dec_pending <= dec_match && dec_param_ok && !dec_bad_frame;
			dec_replace <= dec_replace && !dec_bad_frame;
		end else if (dec_state_clear || (out_valid && out_done)) begin
			dec_replace <= 1'b0;
			dec_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoder output: de-emphasis and homing frame substitution.

	logic               syn_take;
	logic signed [15:0] deemph_mem;
	logic signed [31:0] deemph_prod;
	logic signed [31:0] deemph_sum;
	logic signed [15:0] next_deemph;

	assign syn_ready = (dec_state == homing_pkg::DEC_SYNTH);
	assign syn_take  = syn_valid && syn_ready;
	assign out_done  = (out_count == 8'h00);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_state <= homing_pkg::DEC_PARAMS;
		end else begin
			case (dec_state)
				homing_pkg::DEC_PARAMS: begin
					if (dec_ptake && dec_idx == `DEC_LAST_IDX) begin
						dec_state <= homing_pkg::DEC_SYNTH;
					end
				end
				homing_pkg::DEC_SYNTH: begin
					if (syn_take && out_count == `FRAME_LAST_SAMPLE) begin
						dec_state <= homing_pkg::DEC_PARAMS;
					end
				end
				default: dec_state <= homing_pkg::DEC_PARAMS;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			out_count <= 8'h00;
		end else if (syn_take) begin
			out_count <= (out_count == `FRAME_LAST_SAMPLE) ? 8'h00 : out_count + 8'h01;
		end
	end

	always_comb begin
		deemph_prod = `DEEMPH_BETA * 32'(deemph_mem);
		deemph_sum  = 32'($signed(syn_sample)) + ((deemph_prod + `DEEMPH_ROUND) >>> `Q15_SHIFT);
		if (deemph_sum > 32'(`SAT_POS)) begin
			next_deemph = `SAT_POS;
		end else if (deemph_sum < 32'(`SAT_NEG)) begin
			next_deemph = `SAT_NEG;
		end else begin
			next_deemph = deemph_sum[15:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || dec_state_clear) begin
			deemph_mem <= 16'sh0000;
		end else if (syn_take) begin
			deemph_mem <= next_deemph;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			out_valid  <= 1'b0;
			out_sample <= 16'h0000;
		end else begin
			out_valid <= syn_take;
			if (syn_take) begin
				out_sample <= dec_replace ? `ENC_HOME_SAMPLE : next_deemph;
			end
		end
	end

	// home after the whole frame is out
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_state_clear <= 1'b0;
			dec_home        <= 1'b1;
		end else begin
			dec_state_clear <= syn_take && out_count == `FRAME_LAST_SAMPLE && dec_pending;
			if (syn_take && out_count == `FRAME_LAST_SAMPLE) begin
				dec_home <= dec_pending;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_enc_homing_end;
		enc_take && enc_count == `FRAME_LAST_SAMPLE && enc_match && enc_sample_ok;
	endsequence

	sequence s_enc_done;
		enc_state == homing_pkg::ENC_WAIT && enc_frame_done;
	endsequence

	property p_enc_detect;
		@(posedge mclk) disable iff (!rst_b)
		s_enc_homing_end |=> enc_state == homing_pkg::ENC_WAIT && enc_pending;
	endproperty
	a_enc_detect: assert property (p_enc_detect) else $error("encoder homing frame missed");

	property p_enc_bad_sample;
		@(posedge mclk) disable iff (!rst_b)
		enc_take && !enc_sample_ok |=> !enc_match || enc_count == 8'h00;
	endproperty
	a_enc_bad_sample: assert property (p_enc_bad_sample) else $error("bad sample not noted");

	property p_enc_home_after_done;
		@(posedge mclk) disable iff (!rst_b)
		(s_enc_done and enc_pending) |=> enc_state_clear && enc_home ##1 !enc_state_clear;
	endproperty
	a_enc_home_after_done: assert property (p_enc_home_after_done) else $error("encoder not homed");

	property p_enc_no_early_home;
		@(posedge mclk) disable iff (!rst_b)
		enc_state_clear |-> $past(enc_frame_done) && $past(enc_state) == homing_pkg::ENC_WAIT;
	endproperty
	a_enc_no_early_home: assert property (p_enc_no_early_home) else $error("encoder homed early");

	property p_enc_flag_clear;
		@(posedge mclk) disable iff (!rst_b)
		(s_enc_done and !enc_pending) |=> !enc_home && !enc_state_clear;
	endproperty
	a_enc_flag_clear: assert property (p_enc_flag_clear) else $error("encoder flag kept");

	property p_dec_bad_frame;
		@(posedge mclk) disable iff (!rst_b)
		dec_ptake && dec_idx == `DEC_LAST_IDX && dec_bad_frame |=> !dec_pending && !dec_replace;
	endproperty
	a_dec_bad_frame: assert property (p_dec_bad_frame) else $error("bad frame homed");

	property p_dec_replace;
		@(posedge mclk) disable iff (!rst_b)
		syn_take && dec_replace |=> out_valid && out_sample == `ENC_HOME_SAMPLE;
	endproperty
	a_dec_replace: assert property (p_dec_replace) else $error("homing sample not output");

	property p_dec_home_clear;
		@(posedge mclk) disable iff (!rst_b)
		syn_take && out_count == `FRAME_LAST_SAMPLE && dec_pending
			|=> dec_state_clear && dec_home ##1 deemph_mem == 16'sh0000;
	endproperty
	a_dec_home_clear: assert property (p_dec_home_clear) else $error("decoder not homed");

	property p_deemph_zero_in;
		@(posedge mclk) disable iff (!rst_b)
		syn_take && !dec_replace && syn_sample == 16'h0000 && deemph_mem == 16'sh0000
			|=> out_sample == 16'h0000;
	endproperty
	a_deemph_zero_in: assert property (p_deemph_zero_in) else $error("filter not at rest");

endmodule // codec_homing

`default_nettype wire

// ### bench/codec_partner.sv
// Behavioural sample source and coded-parameter channel for the homing block.
`timescale 1ns/1ps
`default_nettype none
module codec_partner (
	input  wire logic   mclk,
	input  wire logic   enc_sample_ready,
	input  wire logic   dec_param_ready,
	input  wire logic   syn_ready,
	output logic        enc_sample_valid,
	output logic [15:0] enc_sample,
	output logic        enc_frame_done,
	output logic        dec_param_valid,
	output logic [15:0] dec_param,
	output logic        dec_bad_frame,
	output logic        syn_valid,
	output logic [15:0] syn_sample
);
	initial begin
		enc_sample_valid = 1'b0;
		enc_sample = 16'h5a5a;
		enc_frame_done = 1'b0;
		dec_param_valid = 1'b0;
		dec_param = 16'h5a5a;
		dec_bad_frame = 1'b0;
		syn_valid = 1'b0;
		syn_sample = 16'h5a5a;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Valid stays up across a frame so it is never lowered and raised in one step.
	task automatic offer(input int ch, input logic [15:0] v);
		case (ch)
			0: begin
				enc_sample_valid = 1'b1;
				enc_sample = v;
			end
			1: begin
				dec_param_valid = 1'b1;
				dec_param = v;
			end
			default: begin
				syn_valid = 1'b1;
				syn_sample = v;
			end
		endcase
		while ((ch == 0 ? enc_sample_ready : ch == 1 ? dec_param_ready : syn_ready) !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
	endtask
	task automatic enc_frame(input int odd_idx);
		for (int i = 0; i < 160; i++)
			offer(0, i == odd_idx ? 16'h0010 : 16'h000f);
		enc_sample_valid = 1'b0;
		enc_sample = ~enc_sample;
		enc_frame_done = 1'b1;
		@(posedge mclk);
		#1;
		enc_frame_done = 1'b0;
	endtask
	task automatic dec_frame(input logic bad, input int odd_idx, input logic [15:0] syn);
		logic [15:0] lar [8] = '{16'h0009, 16'h0017, 16'h000f, 16'h0008,
			16'h0007, 16'h0003, 16'h0003, 16'h0002};
		logic [15:0] p;
		int          k;
		dec_bad_frame = bad;
		for (int i = 0; i < 76; i++) begin
			k = (i - 8) % 17;
			if (i < 8)
				p = lar[i];
			else if (k == 0)
				p = 16'h0028;
			else if (k < 4)
				p = 16'h0000;
			else
				p = i == 67 ? 16'h0003 : 16'h0004;
			if (i == odd_idx)
				p = p ^ 16'h0001;
			offer(1, p | 16'ha500);
		end
		dec_param_valid = 1'b0;
		dec_param = ~dec_param;
		for (int i = 0; i < 160; i++)
			offer(2, syn);
		syn_valid = 1'b0;
		syn_sample = ~syn_sample;
		dec_bad_frame = 1'b0;
	endtask
endmodule // codec_partner
`default_nettype wire

// ### bench/speech_codec_homing_tb_top.sv
// Self-checking testbench for the codec homing block.
`timescale 1ns/1ps
`default_nettype none
module speech_codec_homing_tb_top;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        enc_sample_valid, enc_sample_ready, enc_frame_done;
	logic        enc_state_clear, enc_home, dec_param_valid, dec_bad_frame;
	logic        dec_param_ready, syn_valid, syn_ready, out_valid;
	logic        dec_state_clear, dec_home;
	logic [15:0] enc_sample, dec_param, syn_sample, out_sample;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n_enc_clr = 0;
	int          n_dec_clr = 0;
	int          n_out = 0;
	int          mode = 0;
	int          prev = 0;
	int          e;

	always #2.5 mclk = ~mclk;

	codec_homing codec_homing_i (.mclk(mclk), .rst_b(rst_b),
		.enc_sample_valid(enc_sample_valid), .enc_sample(enc_sample),
		.enc_sample_ready(enc_sample_ready), .enc_frame_done(enc_frame_done),
		.enc_state_clear(enc_state_clear), .enc_home(enc_home),
		.dec_param_valid(dec_param_valid), .dec_param(dec_param),
		.dec_bad_frame(dec_bad_frame), .dec_param_ready(dec_param_ready),
		.syn_valid(syn_valid), .syn_sample(syn_sample), .syn_ready(syn_ready),
		.out_valid(out_valid), .out_sample(out_sample),
		.dec_state_clear(dec_state_clear), .dec_home(dec_home));

	codec_partner codec_partner_i (.mclk(mclk), .enc_sample_ready(enc_sample_ready),
		.dec_param_ready(dec_param_ready), .syn_ready(syn_ready),
		.enc_sample_valid(enc_sample_valid), .enc_sample(enc_sample),
		.enc_frame_done(enc_frame_done), .dec_param_valid(dec_param_valid),
		.dec_param(dec_param), .dec_bad_frame(dec_bad_frame),
		.syn_valid(syn_valid), .syn_sample(syn_sample));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// The model filter memory follows the design and drops to zero on every decoder state clear.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
		if (enc_state_clear === 1'b1)
			n_enc_clr++;
		if (out_valid === 1'b1) begin
			n_out++;
			if (mode == 1)
				check("replaced sample", out_sample, 16'h0008);
			if (mode == 2) begin
				e = 6144 + ((28180 * prev + 16384) >>> 15);
				if (e > 32767)
					e = 32767;
				check("filtered sample", out_sample, e[15:0]);
				prev = e;
			end
		end
		if (dec_state_clear === 1'b1) begin
			n_dec_clr++;
			prev = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic enc_case(input int odd, input logic home);
		int c0;
		c0 = n_enc_clr;
		codec_partner_i.enc_frame(odd);
		repeat (3) @(posedge mclk);
		#1;
		check("enc clears", 16'(n_enc_clr - c0), {15'h0000, home});
		check("enc_home", {15'h0000, enc_home}, {15'h0000, home});
	endtask

	task automatic dec_case(input logic bad, input int odd, input int md, input logic clr);
		int c0;
		c0 = n_dec_clr;
		n_out = 0;
		mode = md;
		codec_partner_i.dec_frame(bad, odd, 16'h1800);
		repeat (3) @(posedge mclk);
		#1;
		mode = 0;
		check("out count", 16'(n_out), 16'h00a0);
		check("dec clears", 16'(n_dec_clr - c0), {15'h0000, clr});
		check("dec_home", {15'h0000, dec_home}, {15'h0000, clr});
	endtask

	task automatic sc_encoder();
		enc_case(-1, 1'b1);
		enc_case(0, 1'b0);
		enc_case(159, 1'b0);
		enc_case(-1, 1'b1);
		enc_case(-1, 1'b1);
	endtask

	task automatic sc_decoder();
		dec_case(1'b0, -1, 1, 1'b1);
		dec_case(1'b1, -1, 2, 1'b0);
		dec_case(1'b0, -1, 2, 1'b1);
		dec_case(1'b0, -1, 1, 1'b1);
		dec_case(1'b0, 3, 2, 1'b0);
		dec_case(1'b0, -1, 2, 1'b1);
		dec_case(1'b0, 67, 1, 1'b0);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		check("enc_home reset", {15'h0000, enc_home}, 16'h0001);
		check("dec_home reset", {15'h0000, dec_home}, 16'h0001);
		sc_encoder();
		sc_decoder();
		give_verdict();
	end
endmodule // speech_codec_homing_tb_top
`default_nettype wire
